// ### nps_pkg.sv
package nps_pkg;
	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned T_R_NS = 15000;
	localparam int unsigned T_CRY_NS = 5000;
	localparam int unsigned T_RST_NS = 5000;
	localparam logic [8:0] T_R_CYC = 9'((T_R_NS * (CLK_HZ / 1_000_000)) / 1000);
	localparam logic [8:0] T_CRY_CYC = 9'((T_CRY_NS * (CLK_HZ / 1_000_000)) / 1000);
	localparam logic [8:0] T_RST_CYC = 9'((T_RST_NS * (CLK_HZ / 1_000_000)) / 1000);

	// ==========================================================
	// page geometry
	localparam logic [9:0] COL_FIRST = 10'h000;
	localparam logic [9:0] HALF_B_BASE = 10'h100;
	localparam logic [9:0] SPARE_BASE = 10'h200;
	localparam logic [9:0] PAGE_LAST = 10'h20F;
	localparam int unsigned PAGE_BYTES = 528;
	localparam int unsigned PROT_BLOCKS = 256;

	// ==========================================================
	// command codes
	localparam logic [7:0] CMD_READ_A = 8'h00;
	localparam logic [7:0] CMD_READ_B = 8'h01;
	localparam logic [7:0] CMD_READ_C = 8'h50;
	localparam logic [7:0] CMD_PROG_LOAD = 8'h80;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_ERASE_SET = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_BSTAT = 8'h7A;
	localparam logic [7:0] CMD_ID = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] CMD_PROT_P = 8'h41;
	localparam logic [7:0] CMD_PROT_E = 8'h42;
	localparam logic [7:0] CMD_PROT_PE = 8'h43;

	// ==========================================================
	// status fields
	localparam int unsigned SB_FAIL = 0;
	localparam int unsigned SB_READY = 6;
	localparam int unsigned SB_WP = 7;
	localparam int unsigned BS_PROG = 0;
	localparam int unsigned BS_ERASE = 1;

	// identification bytes, values arbitrary
	localparam logic [7:0] ID_MAKER = 8'hA1;
	localparam logic [7:0] ID_DEVICE = 8'hB2;
	localparam logic [7:0] ID_THIRD = 8'hC3;
	localparam logic [7:0] ID_FOURTH = 8'hD4;
	localparam logic [31:0] ID_BYTES = {ID_FOURTH, ID_THIRD, ID_DEVICE, ID_MAKER};

	// ==========================================================
	// pointer areas and array operations
	localparam logic [1:0] PTR_A = 2'h0;
	localparam logic [1:0] PTR_B = 2'h1;
	localparam logic [1:0] PTR_C = 2'h2;
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_PROG = 2'h1;
	localparam logic [1:0] OP_ERASE = 2'h2;
	localparam logic [1:0] OP_PROTECT = 2'h3;

	// ==========================================================
	// types
	typedef enum logic [3:0] {
		ST_READY = 4'h1,
		ST_LOAD = 4'h2,
		ST_ARRAY = 4'h4,
		ST_WAIT = 4'h8
	} nps_st_t;

	typedef enum logic [3:0] {
		RM_DATA = 4'h1,
		RM_STATUS = 4'h2,
		RM_BSTAT = 4'h4,
		RM_ID = 4'h8
	} nps_rm_t;

	typedef enum logic [4:0] {
		PH_NONE = 5'h01,
		PH_READ = 5'h02,
		PH_PROG = 5'h04,
		PH_ERASE = 5'h08,
		PH_ID = 5'h10
	} nps_ph_t;

	typedef struct packed {
		logic req;
		logic abort;
		logic [1:0] op;
		logic [17:0] row;
		logic [1:0] prot;
	} nps_areq_t;

	typedef struct packed {
		nps_st_t st;
		nps_rm_t rm;
		nps_ph_t ph;
		logic [1:0] acnt;
		logic addr_ok;
		logic [1:0] ptr;
		logic [9:0] col;
		logic [17:0] row;
		logic [1:0] prot;
		logic fail;
		logic inval;
		logic [8:0] tcnt;
		logic [9:0] rcnt;
		logic [1:0] fcnt;
		logic [7:0] fe0;
		logic [7:0] fe1;
		logic [1:0] idx;
		logic we_d;
		logic re_d;
		logic [7:0] io_out;
		logic [7:0] pg_out;
		logic [PAGE_BYTES-1:0] loaded;
		nps_areq_t areq;
	} nps_state_t;

	localparam nps_state_t STATE_RESET = '{st: ST_READY, rm: RM_DATA, ph: PH_NONE,
		ptr: PTR_A, we_d: 1'b1, re_d: 1'b1, default: '0};
endpackage

// ### nps_sequencer.sv
`timescale 1ns/1ps
// How it works
// [RL1] power-up: main read mode, first-half pointer
// [RL2] read command plus four addresses starts read
// [RL3] page load holds ready/busy low
// [RL4] chip enable high aborts load, recovery busy
// [RL5] read strobe falling edge outputs next byte
// [RL6] spare read: column 512 plus A0-A3
// [RL7] pointer stays spare until main read
// [RL8] second-half pointer lasts one operation
// [RL9] sequential read loads next page after last
// [RL10] host keeps sequential read within block
// [RL11] program: load command, addresses, data bytes
// [RL12] confirm starts program only after load command and four addresses
// [RL13] host limits partial programs per page
// [RL14] busy program accepts only status, reset
// [RL15] status shows ready and pass/fail
// [RL16] erase: setup, three rows, confirm
// [RL17] protect: type, load, addresses, confirm
// [RL18] protect code selects program/erase lock
// [RL19] protected attempt: busy page time, no change
// [RL20] host protects blocks one to 200 once
// [RL21] block status returns protect flags
// [RL22] pointer commands select columns 0/256/512
// [RL23] read status returns operation status byte
// [RL24] reset aborts, clears, busy reset time
// [RL25] identification returns id bytes in order
// [RL26] strobes latch command or address on rise
// [RL27] undefined commands have no effect
module nps_sequencer (
	input wire logic CLOCK_IN,
	input wire logic NRST_IN,
	input wire logic CE_N_IN,
	input wire logic CLE_IN,
	input wire logic ALE_IN,
	input wire logic WE_N_IN,
	input wire logic OUTPUT_STROBE_N_IN,
	input wire logic WP_N_IN,
	input wire logic [7:0] IO_IN,
	output logic [7:0] IO_OUT,
	output logic IO_OE_OUT,
	output logic RB_N_OUT,
	output logic RB_OE_OUT,
	output logic ARR_REQ_OUT,
	output logic [1:0] ARR_OP_OUT,
	output logic [17:0] ARR_ROW_OUT,
	output logic [1:0] ARR_PROT_OUT,
	output logic ARR_ABORT_OUT,
	input wire logic ARR_RD_VALID_IN,
	input wire logic [7:0] ARR_RD_DATA_IN,
	output logic ARR_RD_READY_OUT,
	input wire logic ARR_DONE_IN,
	input wire logic ARR_FAIL_IN,
	input wire logic [9:0] ARR_PG_ADDR_IN,
	output logic [7:0] ARR_PG_DATA_OUT
);
	nps_pkg::nps_state_t s;
	nps_pkg::nps_state_t n;
	logic [7:0] page [0:nps_pkg::PAGE_BYTES-1];
	logic [1:0] prot_mem [0:nps_pkg::PROT_BLOCKS-1];
	logic pg_we;
	logic [9:0] pg_wa;
	logic [7:0] pg_wd;
	logic fl_we;
	logic [1:0] fl_wd;
	logic we_rise;
	logic re_fall;
	logic rdy;
	logic blk_low;
	logic [1:0] flags;
	logic push;
	logic pop;
	logic start_rd;
	logic start_op;
	logic [1:0] rsel;
	logic [7:0] stat;
	logic [7:0] bstat;

	// ==========================================================
	// next state
	always_comb begin
		n = s;
		n.areq.req = 1'b0;
		n.areq.abort = 1'b0;
		n.we_d = WE_N_IN;
		n.re_d = OUTPUT_STROBE_N_IN;
		pg_we = 1'b0;
		pg_wa = s.col;
		pg_wd = IO_IN;
		fl_we = 1'b0;
		fl_wd = 2'b00;
		start_rd = 1'b0;
		start_op = 1'b0;
		we_rise = !s.we_d && WE_N_IN && !CE_N_IN; // see [RL26]
		re_fall = s.re_d && !OUTPUT_STROBE_N_IN && !CE_N_IN;
		rdy = (s.st == nps_pkg::ST_READY);
		blk_low = (s.row[17:13] == 5'h00);
		flags = blk_low ? prot_mem[s.row[12:5]] : 2'b00;
		rsel = (s.ph == nps_pkg::PH_ERASE) ? 2'(s.acnt + 2'd1) : s.acnt;
		stat = 8'h00;
		stat[nps_pkg::SB_WP] = WP_N_IN;
		stat[nps_pkg::SB_READY] = rdy; // see [RL15]
		stat[nps_pkg::SB_FAIL] = s.fail;
		bstat = 8'h00;
		bstat[nps_pkg::SB_WP] = WP_N_IN;
		bstat[nps_pkg::SB_READY] = rdy;
		bstat[nps_pkg::BS_PROG] = flags[nps_pkg::BS_PROG]; // see [RL21]
		bstat[nps_pkg::BS_ERASE] = flags[nps_pkg::BS_ERASE];
		n.pg_out = s.loaded[ARR_PG_ADDR_IN] ? page[ARR_PG_ADDR_IN] : 8'hFF;

		// two-entry buffer between array stream and page register
		push = ARR_RD_VALID_IN && (s.fcnt != 2'h2);
		pop = (s.fcnt != 2'h0) && (s.st == nps_pkg::ST_LOAD);
		case ({push, pop})
			2'b10: begin
				if (s.fcnt == 2'h0) n.fe0 = ARR_RD_DATA_IN;
				else n.fe1 = ARR_RD_DATA_IN;
				n.fcnt = 2'(s.fcnt + 2'h1);
			end
			2'b01: begin
				n.fe0 = s.fe1;
				n.fcnt = 2'(s.fcnt - 2'h1);
			end
			2'b11: begin
				n.fe0 = (s.fcnt == 2'h1) ? ARR_RD_DATA_IN : s.fe1;
				n.fe1 = ARR_RD_DATA_IN;
			end
			default: begin
			end
		endcase
		if (pop) begin
			pg_we = 1'b1;
			pg_wa = s.rcnt;
			pg_wd = s.fe0;
			n.rcnt = 10'(s.rcnt + 10'h001);
		end

		// busy periods
		case (s.st)
			nps_pkg::ST_LOAD: begin
				if (CE_N_IN) begin
					n.areq.abort = 1'b1; // see [RL4]
					n.st = nps_pkg::ST_WAIT;
					n.tcnt = nps_pkg::T_CRY_CYC;
					n.inval = 1'b1;
				end else if (pop && s.rcnt == nps_pkg::PAGE_LAST) begin
					n.st = nps_pkg::ST_READY; // see [RL3]
				end
			end
			nps_pkg::ST_ARRAY: begin
				if (ARR_DONE_IN) begin
					n.st = nps_pkg::ST_READY;
					n.fail = ARR_FAIL_IN; // see [RL15]
					if (!ARR_FAIL_IN && blk_low && s.areq.op == nps_pkg::OP_ERASE) begin
						fl_we = 1'b1; // see [RL18]
					end
					if (!ARR_FAIL_IN && blk_low && s.areq.op == nps_pkg::OP_PROTECT) begin
						fl_we = 1'b1;
						fl_wd = flags | s.areq.prot;
					end
				end
			end
			nps_pkg::ST_WAIT: begin
				if (s.tcnt <= 9'h001) n.st = nps_pkg::ST_READY;
				else n.tcnt = 9'(s.tcnt - 9'h001);
			end
			default: begin
			end
		endcase

		// command cycles
		if (we_rise && CLE_IN) begin
			if (IO_IN == nps_pkg::CMD_RESET) begin
				if (!rdy) n.areq.abort = 1'b1; // see [RL24]
				n.st = nps_pkg::ST_WAIT;
				n.tcnt = nps_pkg::T_RST_CYC;
				n.acnt = 2'h0;
				n.ph = nps_pkg::PH_NONE;
				n.rm = nps_pkg::RM_DATA;
				n.prot = 2'b00;
				n.fail = 1'b0;
				start_op = 1'b1;
			end else if (IO_IN == nps_pkg::CMD_STATUS) begin
				n.rm = nps_pkg::RM_STATUS; // see [RL23]
			end else if (rdy) begin // see [RL14]
				if (IO_IN != nps_pkg::CMD_PROG_LOAD) n.prot = 2'b00;
				case (IO_IN)
					nps_pkg::CMD_READ_A, nps_pkg::CMD_READ_B, nps_pkg::CMD_READ_C: begin
						n.ptr = (IO_IN == nps_pkg::CMD_READ_A) ? nps_pkg::PTR_A : // see [RL22]
							(IO_IN == nps_pkg::CMD_READ_B) ? nps_pkg::PTR_B : nps_pkg::PTR_C;
						n.ph = nps_pkg::PH_READ; // see [RL7]
						n.acnt = 2'h0;
						n.rm = nps_pkg::RM_DATA;
					end
					nps_pkg::CMD_PROG_LOAD: begin
						n.ph = nps_pkg::PH_PROG; // see [RL11]
						n.acnt = 2'h0;
						n.addr_ok = 1'b0;
						n.loaded = '0;
					end
					nps_pkg::CMD_PROG_GO: begin
						if (s.ph == nps_pkg::PH_PROG && s.addr_ok) begin // see [RL12]
							start_op = 1'b1;
							n.rm = nps_pkg::RM_STATUS;
							n.ph = nps_pkg::PH_NONE;
							if (s.prot != 2'b00) begin
								n.st = nps_pkg::ST_ARRAY; // see [RL17]
								n.areq.req = 1'b1;
								n.areq.op = nps_pkg::OP_PROTECT;
							end else if (flags[nps_pkg::BS_PROG]) begin
								n.st = nps_pkg::ST_WAIT; // see [RL19]
								n.tcnt = nps_pkg::T_R_CYC;
								n.fail = 1'b1;
							end else begin
								n.st = nps_pkg::ST_ARRAY;
								n.areq.req = 1'b1;
								n.areq.op = nps_pkg::OP_PROG;
							end
						end else begin
							n.prot = s.prot;
						end
					end
					nps_pkg::CMD_ERASE_SET: begin
						n.ph = nps_pkg::PH_ERASE; // see [RL16]
						n.acnt = 2'h0;
						n.addr_ok = 1'b0;
					end
					nps_pkg::CMD_ERASE_GO: begin
						if (s.ph == nps_pkg::PH_ERASE && s.addr_ok) begin
							start_op = 1'b1;
							n.rm = nps_pkg::RM_STATUS;
							n.ph = nps_pkg::PH_NONE;
							if (flags[nps_pkg::BS_ERASE]) begin
								n.st = nps_pkg::ST_WAIT; // see [RL19]
								n.tcnt = nps_pkg::T_R_CYC;
								n.fail = 1'b1;
							end else begin
								n.st = nps_pkg::ST_ARRAY;
								n.areq.req = 1'b1;
								n.areq.op = nps_pkg::OP_ERASE;
							end
						end else begin
							n.prot = s.prot;
						end
					end
					nps_pkg::CMD_BSTAT: n.rm = nps_pkg::RM_BSTAT;
					nps_pkg::CMD_ID: begin
						n.ph = nps_pkg::PH_ID; // see [RL25]
						n.acnt = 2'h0;
						n.rm = nps_pkg::RM_ID;
						n.idx = 2'h0;
					end
					nps_pkg::CMD_PROT_P, nps_pkg::CMD_PROT_E, nps_pkg::CMD_PROT_PE: begin
						n.prot = IO_IN[1:0]; // see [RL18]
					end
					default: n.prot = s.prot; // see [RL27]
				endcase
			end
		end else if (we_rise && ALE_IN && rdy) begin
			if (s.acnt != 2'h3) n.acnt = 2'(s.acnt + 2'h1);
			if (s.ph == nps_pkg::PH_ID) begin
				n.idx = 2'h0;
			end else if (s.ph != nps_pkg::PH_NONE || s.rm == nps_pkg::RM_DATA) begin // see [RL1]
				case (rsel)
					2'h0: begin
						if (s.ptr == nps_pkg::PTR_C) n.col = nps_pkg::SPARE_BASE | {6'h00, IO_IN[3:0]}; // see [RL6]
						else if (s.ptr == nps_pkg::PTR_B) n.col = nps_pkg::HALF_B_BASE | {2'h0, IO_IN};
						else n.col = {2'h0, IO_IN};
					end
					2'h1: n.row[7:0] = IO_IN;
					2'h2: n.row[15:8] = IO_IN;
					default: begin
						n.row[17:16] = IO_IN[1:0];
						n.addr_ok = 1'b1;
						if (s.ph == nps_pkg::PH_READ || s.ph == nps_pkg::PH_NONE) begin
							start_rd = 1'b1; // see [RL2]
							n.ph = nps_pkg::PH_NONE;
						end
					end
				endcase
			end
		end else if (we_rise && rdy && !ALE_IN && s.ph == nps_pkg::PH_PROG && s.addr_ok
				&& s.prot == 2'b00) begin
			pg_we = 1'b1; // see [RL11]
			n.loaded[s.col] = 1'b1;
			if (s.col != nps_pkg::PAGE_LAST) n.col = 10'(s.col + 10'h001);
		end

		// read cycles
		case (s.rm)
			nps_pkg::RM_STATUS: n.io_out = stat;
			nps_pkg::RM_BSTAT: n.io_out = bstat;
			nps_pkg::RM_ID: begin
				if (re_fall) begin
					n.io_out = nps_pkg::ID_BYTES[{s.idx, 3'b000} +: 8];
					if (s.idx != 2'h3) n.idx = 2'(s.idx + 2'h1);
				end
			end
			default: begin
				if (re_fall && rdy) begin
					n.io_out = page[s.col]; // see [RL5]
					if (s.col != nps_pkg::PAGE_LAST) begin
						n.col = 10'(s.col + 10'h001);
					end else begin
						n.row = 18'(s.row + 18'h00001); // see [RL9]
						n.col = (s.ptr == nps_pkg::PTR_C) ? nps_pkg::SPARE_BASE : nps_pkg::COL_FIRST;
						start_rd = 1'b1;
					end
				end
			end
		endcase

		if (start_rd) begin
			start_op = 1'b1;
			n.st = nps_pkg::ST_LOAD; // see [RL3]
			n.rcnt = 10'h000;
			n.acnt = 2'h0;
			n.fcnt = 2'h0;
			n.inval = 1'b0;
			n.areq.req = 1'b1;
			n.areq.op = nps_pkg::OP_READ;
		end
		if (n.areq.req) begin
			n.areq.row = n.row;
			n.areq.prot = s.prot;
		end
		if (start_op && s.ptr == nps_pkg::PTR_B) n.ptr = nps_pkg::PTR_A; // see [RL8]
	end

	// ==========================================================
	// registers and memories
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) s <= nps_pkg::STATE_RESET; // see [RL1]
		else s <= n;
	end

	always_ff @(posedge CLOCK_IN) begin
		if (pg_we) page[pg_wa] <= pg_wd;
	end

	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			for (int i = 0; i < nps_pkg::PROT_BLOCKS; i++) begin
				prot_mem[i] <= 2'b00;
			end
		end else if (fl_we) begin
			prot_mem[s.row[12:5]] <= fl_wd;
		end
	end

	// ==========================================================
	// outputs
	assign IO_OUT = s.io_out;
	assign IO_OE_OUT = !CE_N_IN && !OUTPUT_STROBE_N_IN;
	assign RB_N_OUT = 1'b0;
	assign RB_OE_OUT = (s.st != nps_pkg::ST_READY); // see [RL3]
	assign ARR_REQ_OUT = s.areq.req;
	assign ARR_OP_OUT = s.areq.op;
	assign ARR_ROW_OUT = s.areq.row;
	assign ARR_PROT_OUT = s.areq.prot;
	assign ARR_ABORT_OUT = s.areq.abort;
	assign ARR_RD_READY_OUT = (s.fcnt != 2'h2);
	assign ARR_PG_DATA_OUT = s.pg_out;
endmodule

// ### nps_properties.sv
`timescale 1ns/1ps
// ==========================================================
// port relations of the sequencer
module nps_properties (
	input wire logic CLOCK_IN,
	input wire logic NRST_IN,
	input wire logic CE_N_IN,
	input wire logic OUTPUT_STROBE_N_IN,
	input wire logic [7:0] IO_OUT,
	input wire logic IO_OE_OUT,
	input wire logic RB_N_OUT,
	input wire logic RB_OE_OUT,
	input wire logic ARR_REQ_OUT,
	input wire logic ARR_ABORT_OUT,
	input wire logic ARR_DONE_IN
);
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (!NRST_IN);
	oe_follows_a: assert property (IO_OE_OUT == (!CE_N_IN && !OUTPUT_STROBE_N_IN))
		else $error("output enable does not follow strobes");
	rb_pin_low_a: assert property (RB_N_OUT == 1'b0)
		else $error("ready busy drive level not low");
	req_pulse_a: assert property (ARR_REQ_OUT |=> !ARR_REQ_OUT)
		else $error("array request longer than one cycle");
	abort_pulse_a: assert property (ARR_ABORT_OUT |=> !ARR_ABORT_OUT)
		else $error("array abort longer than one cycle");
	abort_busy_a: assert property (ARR_ABORT_OUT |-> RB_OE_OUT)
		else $error("array abort without recovery busy");
	req_busy_a: assert property (ARR_REQ_OUT |-> ##[0:1] RB_OE_OUT)
		else $error("array request without busy");
	busy_no_req_a: assert property (RB_OE_OUT ##1 RB_OE_OUT |-> !ARR_REQ_OUT)
		else $error("new array request while busy");
	done_ready_a: assert property (ARR_DONE_IN |-> ##[1:2] !RB_OE_OUT)
		else $error("busy held after array done");
	reset_idle_a: assert property ($rose(NRST_IN) |-> !RB_OE_OUT && !ARR_REQ_OUT && IO_OUT == 8'h00)
		else $error("state after reset not idle");
endmodule

bind nps_sequencer nps_properties chk_i (.CLOCK_IN(CLOCK_IN), .NRST_IN(NRST_IN),
	.CE_N_IN(CE_N_IN), .OUTPUT_STROBE_N_IN(OUTPUT_STROBE_N_IN), .IO_OUT(IO_OUT),
	.IO_OE_OUT(IO_OE_OUT), .RB_N_OUT(RB_N_OUT), .RB_OE_OUT(RB_OE_OUT),
	.ARR_REQ_OUT(ARR_REQ_OUT), .ARR_ABORT_OUT(ARR_ABORT_OUT), .ARR_DONE_IN(ARR_DONE_IN));

// ### nps_array_model.sv
`timescale 1ns/1ps
// ==========================================================
// cell array: page stream, page register capture, op done
module nps_array_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic req_in,
	input wire logic abort_in,
	input wire logic rd_ready_in,
	input wire logic [1:0] op_in,
	input wire logic [17:0] row_in,
	input wire logic [7:0] pg_data_in,
	output logic rd_valid_out,
	output logic [7:0] rd_data_out,
	output logic done_out,
	output logic [9:0] pg_addr_out
);
	logic [7:0] pg [0:527];
	logic [9:0] cnt;
	logic [7:0] rowb;
	logic rd_act;
	logic op_act;
	logic prog;
	assign rd_valid_out = rd_act;
	// idle data is the inverted count so a stale byte never looks valid
	assign rd_data_out = rd_act ? (cnt[7:0] ^ rowb ^ {6'h00, cnt[9:8]}) : ~cnt[7:0];
	assign pg_addr_out = cnt;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_act <= 1'b0;
			op_act <= 1'b0;
			prog <= 1'b0;
			cnt <= 10'h000;
			rowb <= 8'h00;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (abort_in) begin
				rd_act <= 1'b0;
				op_act <= 1'b0;
			end else if (req_in) begin
				cnt <= 10'h000;
				rowb <= row_in[7:0];
				rd_act <= (op_in == nps_pkg::OP_READ);
				op_act <= (op_in != nps_pkg::OP_READ);
				prog <= (op_in == nps_pkg::OP_PROG);
			end else if (rd_act && rd_ready_in) begin
				cnt <= cnt + 10'h001;
				if (cnt == 10'h20F) rd_act <= 1'b0;
			end else if (op_act) begin
				cnt <= cnt + 10'h001;
				// only a page program alters the captured cells
				if (prog && cnt != 10'h000 && cnt <= 10'h210) pg[cnt - 10'h001] <= pg_data_in;
				if (cnt == 10'h258) begin
					done_out <= 1'b1;
					op_act <= 1'b0;
				end
			end
		end
	end
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk, rst_n, ce_n, cle, ale, we_n, re_n, wp_n, oe, rbn, rb, req, abt, rdv, rdr, done;
	logic [7:0] io, io_o, pgd, rdd, b;
	logic [1:0] op, prot;
	logic [17:0] row;
	logic [9:0] pga;
	int num_errors = 0;
	int checks = 0;
	nps_sequencer dut (.CLOCK_IN(clk), .NRST_IN(rst_n), .CE_N_IN(ce_n), .CLE_IN(cle),
		.ALE_IN(ale), .WE_N_IN(we_n), .OUTPUT_STROBE_N_IN(re_n), .WP_N_IN(wp_n), .IO_IN(io),
		.IO_OUT(io_o), .IO_OE_OUT(oe), .RB_N_OUT(rbn), .RB_OE_OUT(rb), .ARR_REQ_OUT(req),
		.ARR_OP_OUT(op), .ARR_ROW_OUT(row), .ARR_PROT_OUT(prot), .ARR_ABORT_OUT(abt),
		.ARR_RD_VALID_IN(rdv), .ARR_RD_DATA_IN(rdd), .ARR_RD_READY_OUT(rdr),
		.ARR_DONE_IN(done), .ARR_FAIL_IN(1'b0), .ARR_PG_ADDR_IN(pga), .ARR_PG_DATA_OUT(pgd));
	nps_array_model model (.clk_in(clk), .rst_n_in(rst_n), .req_in(req), .abort_in(abt),
		.rd_ready_in(rdr), .op_in(op), .row_in(row), .pg_data_in(pgd), .rd_valid_out(rdv),
		.rd_data_out(rdd), .done_out(done), .pg_addr_out(pga));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ==========================================================
	// report and compare
	task automatic complete_run;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// ==========================================================
	// strobe bus cycles
	task automatic wr(input logic c, input logic a, input logic [7:0] d);
		@(negedge clk);
		cle = c;
		ale = a;
		io = d;
		we_n = 1'b0;
		@(negedge clk);
		we_n = 1'b1;
	endtask
	task automatic adr4(input logic [7:0] col, input logic [7:0] rlo);
		wr(1'b0, 1'b1, col);
		wr(1'b0, 1'b1, rlo);
		wr(1'b0, 1'b1, 8'h00);
		wr(1'b0, 1'b1, 8'h00);
	endtask
	task automatic rd(output logic [7:0] d);
		@(negedge clk);
		re_n = 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		d = io_o;
		re_n = 1'b1;
	endtask
	task automatic rdsts(input logic [7:0] c, input logic [7:0] m, input logic [7:0] e);
		wr(1'b1, 1'b0, c);
		rd(b);
		chk(b & m, e);
	endtask
	task automatic wait_rb(input logic lvl, input int lim);
		int n;
		n = 0;
		while (rb !== lvl && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (rb !== lvl) begin
			chk({7'h00, rb}, {7'h00, lvl});
			complete_run();
		end
	endtask
	task automatic op_go(input logic [7:0] c, input logic [7:0] r, input int lim);
		if (c == 8'h60) begin
			wr(1'b1, 1'b0, 8'h60);
			wr(1'b0, 1'b1, r);
			wr(1'b0, 1'b1, 8'h00);
			wr(1'b0, 1'b1, 8'h00);
			wr(1'b1, 1'b0, 8'hD0);
		end else begin
			if (c != 8'h80) wr(1'b1, 1'b0, c);
			wr(1'b1, 1'b0, 8'h80);
			adr4(8'h00, r);
			wr(1'b1, 1'b0, 8'h10);
		end
		wait_rb(1'b1, 20);
		wait_rb(1'b0, lim);
	endtask
	// ==========================================================
	// scenarios
	initial begin
		rst_n = 1'b0;
		{ce_n, cle, ale, io} = '0;
		{we_n, re_n, wp_n} = 3'h7;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		chk({7'h00, rb}, 8'h00);
		adr4(8'h00, 8'h03);
		wait_rb(1'b1, 20);
		wait_rb(1'b0, 3000);
		rd(b);
		chk(b, 8'h03);
		rdsts(8'h70, 8'hC1, 8'hC0);
		wp_n = 1'b0;
		rdsts(8'h70, 8'h80, 8'h00);
		wp_n = 1'b1;
		wr(1'b1, 1'b0, 8'h00);
		adr4(8'h05, 8'h03);
		wait_rb(1'b1, 20);
		wait_rb(1'b0, 3000);
		for (int i = 5; i < 8; i++) begin
			rd(b);
			chk(b, 8'(i) ^ 8'h03);
		end
		wr(1'b1, 1'b0, 8'h50);
		adr4(8'hF3, 8'h03);
		wait_rb(1'b1, 20);
		wait_rb(1'b0, 3000);
		for (int i = 515; i < 528; i++) begin
			rd(b);
			chk(b, 8'(i) ^ 8'h01);
		end
		wait_rb(1'b1, 50);
		wait_rb(1'b0, 3000);
		rd(b);
		chk(b, 8'h06);
		wr(1'b1, 1'b0, 8'h01);
		adr4(8'h02, 8'h03);
		wait_rb(1'b1, 20);
		wait_rb(1'b0, 3000);
		rd(b);
		chk(b, 8'h00);
		adr4(8'h02, 8'h05);
		wait_rb(1'b1, 20);
		wait_rb(1'b0, 3000);
		rd(b);
		chk(b, 8'h07);
		wr(1'b1, 1'b0, 8'h00);
		adr4(8'h00, 8'h03);
		wait_rb(1'b1, 20);
		ce_n = 1'b1;
		wait_rb(1'b0, 150);
		ce_n = 1'b0;
		wr(1'b1, 1'b0, 8'h90);
		wr(1'b0, 1'b1, 8'h00);
		for (int i = 0; i < 4; i++) begin
			rd(b);
			chk(b, nps_pkg::ID_BYTES[8*i +: 8]);
		end
		wr(1'b1, 1'b0, 8'h10);
		repeat (3) @(negedge clk);
		chk({7'h00, rb}, 8'h00);
		wr(1'b1, 1'b0, 8'h80);
		adr4(8'h00, 8'h20);
		wr(1'b0, 1'b0, 8'hAA);
		wr(1'b0, 1'b0, 8'h55);
		wr(1'b1, 1'b0, 8'h10);
		wait_rb(1'b1, 20);
		rdsts(8'h70, 8'h40, 8'h00);
		wait_rb(1'b0, 3000);
		chk(model.pg[0], 8'hAA);
		chk(model.pg[1], 8'h55);
		chk(model.pg[2], 8'hFF);
		rdsts(8'h70, 8'hC1, 8'hC0);
		for (int k = 0; k < 3; k++) begin
			op_go(8'h41 + 8'(k), 8'h20 * 8'(k + 1), 3000);
			chk({6'h00, prot}, 8'(k + 1));
			rdsts(8'h7A, 8'hC3, 8'hC1 + 8'(k));
		end
		op_go(8'h80, 8'h20, 3000);
		rdsts(8'h70, 8'h01, 8'h01);
		chk(model.pg[0], 8'hAA);
		op_go(8'h60, 8'h60, 3000);
		rdsts(8'h70, 8'h01, 8'h01);
		op_go(8'h60, 8'h20, 3000);
		rdsts(8'h70, 8'h01, 8'h00);
		rdsts(8'h7A, 8'h03, 8'h00);
		wr(1'b1, 1'b0, 8'h00);
		adr4(8'h00, 8'h03);
		wait_rb(1'b1, 20);
		wr(1'b1, 1'b0, 8'hFF);
		wait_rb(1'b0, 150);
		rdsts(8'h70, 8'hC1, 8'hC0);
		complete_run();
	end
endmodule
